//--- rtl/irpw_pkg.sv
`default_nettype none
package irpw_pkg;
    // ==========================================================
    // register byte offsets
    localparam logic [7:0] IRPW_OFS_WCTL = 8'h00;
    localparam logic [7:0] IRPW_OFS_MODE = 8'h04;
    localparam logic [7:0] IRPW_OFS_NCTL = 8'h08;
    localparam logic [7:0] IRPW_OFS_WRH = 8'h0C;
    localparam logic [7:0] IRPW_OFS_WRL = 8'h10;
    localparam logic [7:0] IRPW_OFS_NRH = 8'h14;
    localparam logic [7:0] IRPW_OFS_NRL = 8'h18;
    localparam logic [7:0] IRPW_OFS_CAPH = 8'h1C;
    localparam logic [7:0] IRPW_OFS_CAPL = 8'h20;
    localparam logic [7:0] IRPW_OFS_WCNT = 8'h24;
    // ==========================================================
    // field positions, counter control registers
    localparam int IRPW_B_EN = 7;
    localparam int IRPW_B_SGL = 6;
    localparam int IRPW_B_TO = 5;
    localparam int IRPW_B_CLK = 3;
    localparam int IRPW_B_CMSK = 2;
    localparam int IRPW_B_TMSK = 1;
    localparam int IRPW_B_PSEL = 0;
    // field positions, shared mode control register
    localparam int IRPW_B_MODE = 7;
    localparam int IRPW_B_INSEL = 6;
    localparam int IRPW_B_EDGE = 4;
    localparam int IRPW_B_SUB = 2;
    localparam int IRPW_B_NINIT = 1;
    localparam int IRPW_B_WINIT = 0;
    // ==========================================================
    // codes and values
    localparam logic [1:0] IRPW_SUB_NORM = 2'h0;
    localparam logic [1:0] IRPW_SUB_PP = 2'h1;
    localparam logic [1:0] IRPW_SUB_LO = 2'h2;
    localparam logic [1:0] IRPW_SUB_HI = 2'h3;
    localparam logic [15:0] IRPW_WIDE_ONES = 16'hFFFF;
    localparam logic [15:0] IRPW_WIDE_ONE = 16'h0001;
    localparam logic [7:0] IRPW_NARROW_ONE = 8'h01;
    localparam logic [7:0] IRPW_BYTE_RST = 8'h00;
    // ==========================================================
    // complete block state
    typedef struct packed {
        logic wen;
        logic wsgl;
        logic wto;
        logic [1:0] wclk;
        logic wcmsk;
        logic wtmsk;
        logic wpsel;
        logic demod;
        logic insel;
        logic [1:0] edge_sel;
        logic [1:0] sub;
        logic ninit;
        logic winit;
        logic nen;
        logic nsgl;
        logic nto;
        logic ntmsk;
        logic [7:0] wrh;
        logic [7:0] wrl;
        logic [7:0] nrh;
        logic [7:0] nrl;
        logic [15:0] cap;
        logic [15:0] wcnt;
        logic [7:0] ncnt;
        logic wout;
        logic nout;
        logic [2:0] presc;
        logic wrun;
        logic rearm;
        logic in_prev;
        logic wto_irq;
        logic wcap_irq;
        logic nto_irq;
        logic [31:0] prdata;
    } irpw_state_t;
    localparam irpw_state_t IRPW_STATE_RST = '0;
endpackage
`default_nettype wire

//--- rtl/irpw_counter.sv
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - transmit enable loads high*256+low reload and drives initial output
// - transmit terminal count toggles output, sets time-out, may interrupt
// - single pass stops at terminal count, auto-reload reloads and runs
// - reload writes only take effect at the next counter load
// - transmit zero wraps to all ones without a time-out
// - first selected edge after enable captures, reloads, starts counting
// - later edge captures complemented count, sets flag, reloads ones
// - edge ignore keeps counting; narrow time-out captures without reload
// - writing ignore zero then one rearms one capture on next edge
// - demodulation zero continues from all ones, sets time-out
// - alternation starts from either enable; narrow loads by level
// - terminal counts hand over between narrow and wide forever
// - submode zero-zero ends alternation
// - hardware toggles enables and sets each time-out in alternation
// - each counter interrupts on terminal count under its own mask
// - counters run regardless of processor halt
// - wide counter prescaler divides by one, two, four or eight
// - wide time-out flag sets at terminal; write one clears
// - rising and falling edge flags set on selected edges; write one clears
// - submode ten forces wide output low, eleven forces it high
module irpw_counter
    import irpw_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic demod_in_a,
    input wire logic demod_in_b,
    output logic wide_counter_output,
    output logic narrow_counter_output,
    output logic wide_out_pin_en,
    output logic wide_timeout_irq,
    output logic wide_capture_irq,
    output logic narrow_timeout_irq
);
    // ==========================================================
    // helpers
    function automatic logic [2:0] irpw_pmask(input logic [1:0] code);
        logic [2:0] m;
        m = 3'h0;
        unique case (code)
            2'h0: m = 3'h0;
            2'h1: m = 3'h1;
            2'h2: m = 3'h3;
            2'h3: m = 3'h7;
        endcase
        return m;
    endfunction

    function automatic logic irpw_mapped(input logic [7:0] a);
        return (a == IRPW_OFS_WCTL) || (a == IRPW_OFS_MODE) ||
            (a == IRPW_OFS_NCTL) || (a == IRPW_OFS_WRH) ||
            (a == IRPW_OFS_WRL) || (a == IRPW_OFS_NRH) ||
            (a == IRPW_OFS_NRL) || (a == IRPW_OFS_CAPH) ||
            (a == IRPW_OFS_CAPL) || (a == IRPW_OFS_WCNT);
    endfunction

    irpw_state_t r;
    irpw_state_t n;
    logic acc;
    logic wr;
    logic tick_w;
    logic din;
    logic rise;
    logic fall;
    logic sel_edge;
    logic pp;
    logic w_start;
    logic n_start;
    logic w_term;
    logic n_term;
    logic edge_cap;
    logic [15:0] wide_reload;
    logic [7:0] wd;

    assign acc = psel & penable;
    assign wr = acc & pwrite;
    assign pready = acc;
    assign pslverr = acc & ~irpw_mapped(paddr);
    assign prdata = r.prdata;
    assign wide_counter_output = r.wout;
    assign narrow_counter_output = r.nout;
    assign wide_out_pin_en = r.wpsel;
    assign wide_timeout_irq = r.wto_irq;
    assign wide_capture_irq = r.wcap_irq;
    assign narrow_timeout_irq = r.nto_irq;
    assign wd = pwdata[7:0];
    // reload bytes are only sampled here, at a load
    assign wide_reload = {r.wrh, r.wrl};

    // ==========================================================
    // next state
    always_comb begin
        n = r;
        n.wto_irq = 1'b0;
        n.wcap_irq = 1'b0;
        n.nto_irq = 1'b0;
        w_start = 1'b0;
        n_start = 1'b0;
        w_term = 1'b0;
        n_term = 1'b0;
        edge_cap = 1'b0;
        pp = ~r.demod && (r.sub == IRPW_SUB_PP);
        // prescaler free-runs; no halt input stops it
        n.presc = r.presc + 3'h1;
        tick_w = (r.presc & irpw_pmask(r.wclk)) ==
            irpw_pmask(r.wclk);
        din = r.insel ? demod_in_b : demod_in_a;
        rise = din & ~r.in_prev;
        fall = ~din & r.in_prev;
        sel_edge = (rise & r.edge_sel[0]) | (fall & r.edge_sel[1]);
        n.in_prev = din;

        // software writes first; hardware sets below win over clears
        if (wr) begin
            unique case (paddr)
                IRPW_OFS_WCTL: begin
                    n.wen = wd[IRPW_B_EN];
                    w_start = wd[IRPW_B_EN] & ~r.wen;
                    if (wd[IRPW_B_EN] == 1'b0) begin
                        n.wrun = 1'b0; // count held
                    end
                    if (r.demod & ~r.wsgl & wd[IRPW_B_SGL]) begin
                        n.rearm = 1'b1;
                    end
                    n.wsgl = wd[IRPW_B_SGL];
                    if (wd[IRPW_B_TO]) begin
                        n.wto = 1'b0;
                    end
                    n.wclk = wd[IRPW_B_CLK +: 2];
                    n.wcmsk = wd[IRPW_B_CMSK];
                    n.wtmsk = wd[IRPW_B_TMSK];
                    n.wpsel = wd[IRPW_B_PSEL];
                end
                IRPW_OFS_MODE: begin
                    n.demod = wd[IRPW_B_MODE];
                    n.insel = wd[IRPW_B_INSEL];
                    n.edge_sel = wd[IRPW_B_EDGE +: 2];
                    n.sub = wd[IRPW_B_SUB +: 2];
                    if (r.demod) begin
                        // low bits are edge flags here
                        n.ninit = r.ninit & ~wd[IRPW_B_NINIT];
                        n.winit = r.winit & ~wd[IRPW_B_WINIT];
                    end else begin
                        n.ninit = wd[IRPW_B_NINIT];
                        n.winit = wd[IRPW_B_WINIT];
                    end
                end
                IRPW_OFS_NCTL: begin
                    n.nen = wd[IRPW_B_EN];
                    n_start = wd[IRPW_B_EN] & ~r.nen;
                    n.nsgl = wd[IRPW_B_SGL];
                    if (wd[IRPW_B_TO]) begin
                        n.nto = 1'b0;
                    end
                    n.ntmsk = wd[IRPW_B_TMSK];
                end
                IRPW_OFS_WRH: n.wrh = wd;
                IRPW_OFS_WRL: n.wrl = wd;
                IRPW_OFS_NRH: n.nrh = wd;
                IRPW_OFS_NRL: n.nrl = wd;
                default: begin
                end
            endcase
        end

        // ======================================================
        // narrow counter: one tick per enabled clock
        if (r.nen && !n_start) begin
            if (r.ncnt == IRPW_NARROW_ONE) begin
                n_term = 1'b1;
                n.nout = ~r.nout;
                n.nto = 1'b1;
                n.nto_irq = r.ntmsk;
                if (r.nsgl || pp) begin
                    n.nen = 1'b0;
                    n.ncnt = 8'h00;
                end else begin
                    n.ncnt = r.nout ? r.nrl : r.nrh;
                end
                if (pp) begin
                    w_start = 1'b1;
                    n.wen = 1'b1;
                end
            end else begin
                n.ncnt = r.ncnt - 8'h01;
            end
        end

        // ======================================================
        // wide counter, transmit
        if (!r.demod && r.wen && !w_start && tick_w) begin
            if (r.wcnt == IRPW_WIDE_ONE) begin
                w_term = 1'b1;
                if (!r.sub[1]) begin
                    n.wout = ~r.wout;
                end
                n.wto = 1'b1;
                n.wto_irq = r.wtmsk;
                if (r.wsgl || pp) begin
                    n.wen = 1'b0;
                    n.wcnt = 16'h0000;
                end else begin
                    n.wcnt = wide_reload;
                end
                if (pp) begin
                    n_start = 1'b1;
                    n.nen = 1'b1;
                end
            end else begin
                // zero wraps to all ones, not a time-out
                n.wcnt = r.wcnt - IRPW_WIDE_ONE;
            end
        end

        // ======================================================
        // wide counter, demodulation
        if (r.demod && rise && r.edge_sel[0]) begin
            n.ninit = 1'b1;
        end
        if (r.demod && fall && r.edge_sel[1]) begin
            n.winit = 1'b1;
        end
        if (r.demod && r.wen && !w_start) begin
            if (sel_edge && (!r.wrun || !r.wsgl || r.rearm)) begin
                n.cap = ~r.wcnt;
                n.rearm = 1'b0;
                n.wrun = 1'b1;
                if (r.wrun) begin
                    edge_cap = 1'b1;
                    n.wcnt = IRPW_WIDE_ONES;
                    n.wcap_irq = r.wcmsk;
                end else begin
                    n.wcnt = wide_reload;
                end
            end else if (r.wrun) begin
                if (n_term && r.wsgl) begin
                    n.cap = ~r.wcnt; // no reload here
                    n.wcap_irq = r.wcmsk;
                end
                if (tick_w) begin
                    if (r.wcnt == 16'h0000) begin
                        n.wcnt = IRPW_WIDE_ONES;
                        n.wto = 1'b1;
                        n.wto_irq = r.wtmsk;
                    end else begin
                        n.wcnt = r.wcnt - IRPW_WIDE_ONE;
                    end
                end
            end
        end

        // ======================================================
        // starts override counting: load and initial level
        if (w_start && !r.demod) begin
            n.wcnt = wide_reload;
            n.wout = r.winit;
        end
        if (w_start && r.demod) begin
            n.wrun = 1'b0; // waits for the first edge
        end
        if (n_start) begin
            n.nout = r.ninit;
            n.ncnt = r.ninit ? r.nrh : r.nrl;
        end
        if (!r.demod && r.sub[1]) begin
            n.wout = r.sub[0];
        end

        // read data is staged in the setup cycle
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                IRPW_OFS_WCTL: n.prdata = {24'h000000, r.wen, r.wsgl,
                    r.wto, r.wclk, r.wcmsk, r.wtmsk, r.wpsel};
                IRPW_OFS_MODE: n.prdata = {24'h000000, r.demod, r.insel,
                    r.edge_sel, r.sub, r.ninit, r.winit};
                IRPW_OFS_NCTL: n.prdata = {24'h000000, r.nen, r.nsgl,
                    r.nto, 3'h0, r.ntmsk, 1'b0};
                IRPW_OFS_WRH: n.prdata = {24'h000000, r.wrh};
                IRPW_OFS_WRL: n.prdata = {24'h000000, r.wrl};
                IRPW_OFS_NRH: n.prdata = {24'h000000, r.nrh};
                IRPW_OFS_NRL: n.prdata = {24'h000000, r.nrl};
                IRPW_OFS_CAPH: n.prdata = {24'h000000, r.cap[15:8]};
                IRPW_OFS_CAPL: n.prdata = {24'h000000, r.cap[7:0]};
                IRPW_OFS_WCNT: n.prdata = {16'h0000, r.wcnt};
                default: n.prdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            r <= IRPW_STATE_RST;
        end else if (clk_en) begin
            r <= n;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence irpw_narrow_end_s;
        clk_en && n_term && pp;
    endsequence

    sequence irpw_wide_loaded_s;
        r.wen && !r.nen && r.wcnt == $past(wide_reload);
    endsequence

    load_on_enable_a: assert property (
        clk_en && w_start && !r.demod && !r.sub[1] |=>
        r.wcnt == $past(wide_reload) && r.wout == $past(r.winit))
        else $error("wide load on enable wrong");

    toggle_at_end_a: assert property (
        clk_en && w_term && !r.sub[1] && !n_start |=>
        r.wout != $past(r.wout) && r.wto)
        else $error("wide terminal count did not toggle");

    single_stop_a: assert property (
        clk_en && w_term && r.wsgl && !w_start |=> !r.wen ##1 !r.wen)
        else $error("single pass did not stop");

    wrap_no_timeout_a: assert property (
        clk_en && !r.demod && r.wen && !w_start && tick_w &&
        r.wcnt == 16'h0000 && !r.wto |=> r.wcnt == 16'hFFFF && !r.wto)
        else $error("zero wrap handled wrong");

    edge_capture_a: assert property (
        clk_en && edge_cap |=> r.cap == ~$past(r.wcnt) &&
        r.wcnt == 16'hFFFF)
        else $error("edge capture wrong");

    force_level_a: assert property (
        clk_en && !r.demod && r.sub[1] |=> r.wout == $past(r.sub[0]))
        else $error("forced output level wrong");

    timeout_set_a: assert property (
        clk_en && w_term |=> r.wto)
        else $error("time-out flag lost against clear");

    handoff_a: assert property (
        irpw_narrow_end_s |=> irpw_wide_loaded_s)
        else $error("narrow to wide handoff wrong");

    prescale_a: assert property (
        clk_en && r.wen && !w_start && !sel_edge && r.wclk == 2'h3 &&
        r.presc != 3'h7 && !(n_term && r.wsgl) |=>
        r.wcnt == $past(r.wcnt))
        else $error("wide counted off its prescaler tick");
endmodule
`default_nettype wire

//--- tb/irpw_ir_far.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// infrared receiver side: one line carries the commanded level
module irpw_ir_far (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic sel_b,
    input wire logic level,
    output logic demod_in_a,
    output logic demod_in_b
);
    // the unused line flips every cycle, so a wrong input select
    // shows up as a burst of spurious edges
    logic pat;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pat <= 1'b0;
        end else begin
            pat <= ~pat;
        end
    end
    assign demod_in_a = sel_b ? pat : level;
    assign demod_in_b = sel_b ? level : pat;
endmodule
`default_nettype wire

//--- tb/ir_pulse_wide_counter_pingpong_tb.sv
`timescale 1ns/10ps
`default_nettype none
module ir_pulse_wide_counter_pingpong_tb;
    import irpw_pkg::*;
    // ==========================================================
    // signals
    localparam int LIMIT = 20000;
    logic clk_sys, rst, clk_en, psel, penable, pwrite, sel_b, level;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic pready, pslverr, din_a, din_b, wout, nout, pin_en;
    logic wto_irq, wcap_irq, nto_irq, out_q, e;
    int err_count, tests_run, cyc, tog_last, tog_prev;
    int n_wto, n_cap, n_nto, t_en, c, w0, n0;

    irpw_counter dut (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .demod_in_a(din_a), .demod_in_b(din_b),
        .wide_counter_output(wout), .narrow_counter_output(nout),
        .wide_out_pin_en(pin_en), .wide_timeout_irq(wto_irq),
        .wide_capture_irq(wcap_irq), .narrow_timeout_irq(nto_irq));
    irpw_ir_far far (.clk_sys(clk_sys), .rst(rst), .sel_b(sel_b),
        .level(level), .demod_in_a(din_a), .demod_in_b(din_b));

    // ==========================================================
    // checking and closing
    task automatic test_done();
        if (err_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // pre-edge samples, so a change made at edge n is logged as n+1
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        out_q <= wout;
        if (wout !== out_q) begin
            tog_prev <= tog_last;
            tog_last <= cyc;
        end
        if (wto_irq === 1'b1) n_wto <= n_wto + 1;
        if (wcap_irq === 1'b1) n_cap <= n_cap + 1;
        if (nto_irq === 1'b1) n_nto <= n_nto + 1;
        if (cyc > LIMIT) begin
            err_count++;
            test_done();
        end
    end
    // ==========================================================
    // bus and stimulus tasks
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [7:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
                       input string name);
        xfer(1'b0, a, 8'h00);
        check(name, q, exp);
    endtask
    task automatic wait_tog();
        int k;
        k = tog_last;
        while (tog_last == k) @(posedge clk_sys);
    endtask
    task automatic pulse();
        @(posedge clk_sys);
        level <= 1'b0;
        repeat (5) @(posedge clk_sys);
        level <= 1'b1;
        repeat (5) @(posedge clk_sys);
    endtask
    // ==========================================================
    // main sequence
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial begin
        {rst, clk_en, psel, penable, pwrite, sel_b, level} = 7'b1100000;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        {err_count, tests_run, cyc, tog_last, tog_prev} = '0;
        {n_wto, n_cap, n_nto} = '0;
        out_q = 1'b0;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        rdc(IRPW_OFS_WCTL, 32'h00000000, "wctl_rst");
        rdc(IRPW_OFS_MODE, 32'h00000000, "mode_rst");
        xfer(1'b0, 8'h30, 8'h00);
        check("unmapped_err", e, 32'h1);
        check("unmapped_rd", q, 32'h0);
        // single pass, count 20, initial level high
        wr(IRPW_OFS_WRH, 8'h00);
        wr(IRPW_OFS_WRL, 8'h14);
        wr(IRPW_OFS_MODE, 8'h01);
        wr(IRPW_OFS_WCTL, 8'hC3);
        t_en = cyc;
        wr(IRPW_OFS_WRL, 8'h05);
        while (n_wto == 0) @(posedge clk_sys);
        repeat (2) @(posedge clk_sys);
        check("start_level", tog_prev - t_en, 32'h1);
        check("term_time", tog_last - t_en, 32'h15);
        check("term_level", wout, 32'h0);
        check("term_irq", n_wto, 32'h1);
        check("pin_en", pin_en, 32'h1);
        rdc(IRPW_OFS_WCTL, 32'h00000063, "single_stop");
        rdc(IRPW_OFS_WCNT, 32'h00000000, "stop_count");
        wr(IRPW_OFS_WCTL, 8'h43);
        rdc(IRPW_OFS_WCTL, 32'h00000063, "to_keep");
        wr(IRPW_OFS_WCTL, 8'h63);
        rdc(IRPW_OFS_WCTL, 32'h00000043, "to_clear");
        // auto-reload at every prescale code, reload now 5
        for (int i = 0; i < 4; i++) begin
            wr(IRPW_OFS_WCTL, {3'b100, 2'(i), 3'b000});
            repeat (3) wait_tog();
            check("period", tog_last - tog_prev, 32'(5 << i));
            wr(IRPW_OFS_WCTL, 8'h00);
        end
        // count of zero wraps without time-out, disable holds count
        c = n_wto;
        // the reload loop leaves the time-out flag set; clear it while stopped
        wr(IRPW_OFS_WCTL, 8'h20);
        wr(IRPW_OFS_WRL, 8'h00);
        wr(IRPW_OFS_WCTL, 8'h80);
        repeat (4) @(posedge clk_sys);
        wr(IRPW_OFS_WCTL, 8'h00);
        xfer(1'b0, IRPW_OFS_WCNT, 8'h00);
        check("wrap_high", q[15:8], 32'hFF);
        check("wrap_no_irq", n_wto, c);
        w0 = q;
        repeat (4) @(posedge clk_sys);
        rdc(IRPW_OFS_WCNT, w0, "hold");
        rdc(IRPW_OFS_WCTL, 32'h00000000, "wrap_no_flag");
        // forced output levels
        wr(IRPW_OFS_MODE, 8'h08);
        repeat (2) @(posedge clk_sys);
        check("force_low", wout, 32'h0);
        wr(IRPW_OFS_MODE, 8'h0C);
        repeat (2) @(posedge clk_sys);
        check("force_high", wout, 32'h1);
        // demodulation, rising edges, edges 40 cycles apart
        wr(IRPW_OFS_WRH, 8'hFF);
        wr(IRPW_OFS_WRL, 8'hFF);
        wr(IRPW_OFS_MODE, 8'h90);
        wr(IRPW_OFS_WCTL, 8'h84);
        @(posedge clk_sys);
        level <= 1'b1;
        repeat (20) @(posedge clk_sys);
        level <= 1'b0;
        c = n_cap;
        repeat (20) @(posedge clk_sys);
        level <= 1'b1;
        repeat (4) @(posedge clk_sys);
        check("cap_irq", n_cap, c + 1);
        rdc(IRPW_OFS_CAPH, 32'h00000000, "cap_high");
        rdc(IRPW_OFS_CAPL, 32'h00000027, "cap_low");
        rdc(IRPW_OFS_MODE, 32'h00000092, "rise_flag");
        wr(IRPW_OFS_MODE, 8'h92);
        rdc(IRPW_OFS_MODE, 32'h00000090, "rise_clear");
        // second input line, no edge selected while switching
        wr(IRPW_OFS_MODE, 8'hC0);
        @(posedge clk_sys);
        sel_b <= 1'b1;
        wr(IRPW_OFS_MODE, 8'hF0);
        c = n_cap;
        pulse();
        check("sel_b_cap", n_cap, c + 2);
        rdc(IRPW_OFS_MODE, 32'h000000F3, "both_flags");
        // edge ignore: one armed capture, then nothing
        wr(IRPW_OFS_WCTL, 8'hC4);
        pulse();
        c = n_cap;
        pulse();
        pulse();
        check("ignore", n_cap, c);
        wr(IRPW_OFS_WCTL, 8'h84);
        wr(IRPW_OFS_WCTL, 8'hC4);
        pulse();
        pulse();
        check("rearm", n_cap, c + 1);
        // narrow time-out while edges are ignored captures once
        c = n_cap;
        wr(IRPW_OFS_NCTL, 8'hC0);
        repeat (300) @(posedge clk_sys);
        check("narrow_cap", n_cap, c + 1);
        // alternation: stop, clear flags, single pass both
        wr(IRPW_OFS_WCTL, 8'h20);
        wr(IRPW_OFS_NCTL, 8'h20);
        wr(IRPW_OFS_MODE, 8'h00);
        wr(IRPW_OFS_NRH, 8'h03);
        wr(IRPW_OFS_NRL, 8'h03);
        wr(IRPW_OFS_WRH, 8'h00);
        wr(IRPW_OFS_WRL, 8'h05);
        wr(IRPW_OFS_WCTL, 8'h42);
        wr(IRPW_OFS_MODE, 8'h04);
        w0 = n_wto;
        n0 = n_nto;
        wr(IRPW_OFS_NCTL, 8'hC2);
        repeat (100) @(posedge clk_sys);
        check("pp_wide", n_wto - w0 > 4, 32'h1);
        check("pp_narrow", n_nto - n0 > 4, 32'h1);
        xfer(1'b0, IRPW_OFS_WCTL, 8'h00);
        check("pp_flag", q[5], 32'h1);
        wr(IRPW_OFS_MODE, 8'h00);
        repeat (20) @(posedge clk_sys);
        w0 = n_wto;
        n0 = n_nto;
        repeat (100) @(posedge clk_sys);
        check("pp_end_wide", n_wto, w0);
        check("pp_end_narrow", n_nto, n0);
        check("pp_end_nout", nout, 32'h1);
        test_done();
    end
endmodule
`default_nettype wire
